// ==== design/pdds_map.vh ====
`ifndef PDDS_MAP_VH
`define PDDS_MAP_VH
`define PDDS_ADDR_PD_CS      5'h15
`define PDDS_ADDR_CTRL_TWO   5'h16
`define PDDS_CTRL_TWO_RESET  16'h0308
`define PDDS_PD_CS_RESET     16'h0000
`define PDDS_BIT_PD_EN       3
`define PDDS_BIT_PULSE_EN    2
`define PDDS_BIT_IN_PD       1
`define PDDS_BIT_RSV0        0
`define PDDS_BIT_HD_CRS      15
`define PDDS_BIT_FALLBACK    11
`define PDDS_CS_WMASK        16'h000d
`define PDDS_QUIET_SECONDS   3
`define PDDS_PULSE_MS        1000
`define PDDS_CLK_HZ          40000000
`define PDDS_BURST_CYCLES    16
`define PDDS_STRAP_SETTLE    2'h2
`endif

// ==== design/pdds_top.v ====
`timescale 1ns/1ps
`include "pdds_map.vh"
module pdds_top #(
  parameter QUIET_CYCLES = `PDDS_QUIET_SECONDS * `PDDS_CLK_HZ,       // quiet time before sleep
  parameter PULSE_CYCLES = (`PDDS_PULSE_MS / 1000) * `PDDS_CLK_HZ,   // wake interval
  parameter BURST_CYCLES = `PDDS_BURST_CYCLES                         // burst length
) (
  input  wire        clk,                // 40 MHz clock
  input  wire        nrst,               // sync reset, active low
  input  wire        mgmt_wr,            // register write strobe
  input  wire        mgmt_rd,            // register read strobe
  input  wire [4:0]  mgmt_addr,          // register address
  input  wire [15:0] mgmt_wdata,         // write data
  output reg  [15:0] mgmt_rdata,         // read data, registered
  input  wire        strap_pulse_pin,    // strap for pulse enable
  input  wire        strap_config_one,   // strap config one
  input  wire        strap_config_zero,  // strap config zero
  input  wire        strap_pd_en_pin,    // strap for power-down enable
  input  wire        energy_pin,         // line energy detected
  input  wire        mac_tx_en,          // mac transmit active
  input  wire        half_duplex,        // link is half duplex
  input  wire        an_enable,          // autonegotiation enabled
  input  wire        adv_fast,           // 100BASE-TX advertised
  input  wire        gig_fail,           // 1000BASE-T bring-up failed
  output reg         sleep_pulse_out,    // pulse burst to line driver
  output reg         in_pd_out,          // in power-down indication
  output reg         crs_out,            // carrier sense to mac
  output reg         fallback_to_fast,   // request 100BASE-TX link
  output reg  [15:0] ctrl_two_out        // second control register value
);
  localparam ST_AWAKE = 2'h0;
  localparam ST_SLEEP = 2'h1;
  localparam ST_BURST = 2'h2;
  localparam SYNC_W   = 5;

  reg  [1:0]        strap_cnt_reg;
  reg               strap_done_reg;
  reg  [1:0]        state_reg;
  reg  [31:0]       cnt_reg;
  reg  [15:0]       ctrl_two_reg;
  reg               pd_en_reg;
  reg               pulse_en_reg;
  reg               rsv0_reg;
  wire [SYNC_W-1:0] pin_vec;
  wire [SYNC_W-1:0] sync_b;
  wire              energy;
  wire              in_pd;
  wire              strap_ready;
  wire              wr_ctrl_two;
  wire              wr_pd_cs;
  wire [15:0]       cs_read;

  // one address compare shared by write and read decode
  function addr_hit;
    input [4:0] addr;
    input [4:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  assign pin_vec     = {strap_pd_en_pin, strap_pulse_pin, strap_config_one, strap_config_zero, energy_pin};
  assign energy      = sync_b[0];
  assign in_pd       = (state_reg != ST_AWAKE);
  assign strap_ready = (strap_cnt_reg == `PDDS_STRAP_SETTLE);
  assign wr_ctrl_two = mgmt_wr && addr_hit(mgmt_addr, `PDDS_ADDR_CTRL_TWO);
  assign wr_pd_cs    = mgmt_wr && addr_hit(mgmt_addr, `PDDS_ADDR_PD_CS);
  assign cs_read     = {12'h000, pd_en_reg, pulse_en_reg, in_pd, rsv0_reg};

  // pins are asynchronous to clk; two stages each
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
      reg stage_a_reg;
      reg stage_b_reg;
      always @(posedge clk) begin
        if (!nrst) begin
          stage_a_reg <= 1'b0;
          stage_b_reg <= 1'b0;
        end else begin
          stage_a_reg <= pin_vec[gi];
          stage_b_reg <= stage_a_reg;
        end
      end
      assign sync_b[gi] = stage_b_reg;
    end
  endgenerate

  // synchroniser still shows reset zeros for two edges; wait before taking straps
  always @(posedge clk) begin
    if (!nrst)
      strap_cnt_reg <= 2'h0;
    else if (!strap_ready)
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
  end

  // writes before strap capture are dropped so defaults are never half-applied
  always @(posedge clk) begin
    if (!nrst) begin
      strap_done_reg <= 1'b0;
      ctrl_two_reg   <= `PDDS_CTRL_TWO_RESET;
      pd_en_reg      <= 1'b0;
      pulse_en_reg   <= 1'b0;
      rsv0_reg       <= 1'b0;
    end else if (!strap_done_reg) begin
      if (strap_ready) begin
        strap_done_reg <= 1'b1;
        pulse_en_reg   <= sync_b[3];
        pd_en_reg      <= sync_b[4];
        ctrl_two_reg[`PDDS_BIT_FALLBACK] <= sync_b[2] & sync_b[1];
      end
    end else begin
      if (wr_ctrl_two)
        ctrl_two_reg <= mgmt_wdata;
      if (wr_pd_cs) begin
        pd_en_reg    <= mgmt_wdata[`PDDS_BIT_PD_EN];
        pulse_en_reg <= mgmt_wdata[`PDDS_BIT_PULSE_EN];
        rsv0_reg     <= mgmt_wdata[`PDDS_BIT_RSV0];
      end
    end
  end

  always @(posedge clk) begin
    if (!nrst)
      mgmt_rdata <= 16'h0000;
    else if (mgmt_rd) begin
      if (addr_hit(mgmt_addr, `PDDS_ADDR_CTRL_TWO))
        mgmt_rdata <= ctrl_two_reg;
      else if (addr_hit(mgmt_addr, `PDDS_ADDR_PD_CS))
        mgmt_rdata <= cs_read;
      else
        mgmt_rdata <= 16'h0000;
    end
  end

  // power-down sequencer; counter reused for quiet, interval and burst
  always @(posedge clk) begin
    if (!nrst) begin
      state_reg <= ST_AWAKE;
      cnt_reg   <= 32'h0000_0000;
    end else begin
      case (state_reg)
        ST_AWAKE: begin
          if (energy || !pd_en_reg)
            cnt_reg <= 32'h0000_0000;
          else if (cnt_reg >= QUIET_CYCLES - 1) begin
            state_reg <= ST_SLEEP;
            cnt_reg   <= 32'h0000_0000;
          end else
            cnt_reg <= cnt_reg + 32'h0000_0001;
        end
        ST_SLEEP: begin
          if (energy) begin
            state_reg <= ST_AWAKE;
            cnt_reg   <= 32'h0000_0000;
          end else if (!pulse_en_reg) begin
            // held at zero so a late enable waits a full interval
            cnt_reg   <= 32'h0000_0000;
          end else if (cnt_reg >= PULSE_CYCLES - 1) begin
            state_reg <= ST_BURST;
            cnt_reg   <= 32'h0000_0000;
          end else
            cnt_reg <= cnt_reg + 32'h0000_0001;
        end
        ST_BURST: begin
          if (energy) begin
            state_reg <= ST_AWAKE;
            cnt_reg   <= 32'h0000_0000;
          end else if (cnt_reg >= BURST_CYCLES - 1) begin
            state_reg <= ST_SLEEP;
            cnt_reg   <= 32'h0000_0000;
          end else
            cnt_reg <= cnt_reg + 32'h0000_0001;
        end
        default: begin
          state_reg <= ST_AWAKE;
          cnt_reg   <= 32'h0000_0000;
        end
      endcase
    end
  end

  // burst gated by live enable so a clear stops pulses at once
  always @(posedge clk) begin
    if (!nrst)
      sleep_pulse_out <= 1'b0;
    else
      sleep_pulse_out <= (state_reg == ST_BURST) && pulse_en_reg;
  end

  always @(posedge clk) begin
    if (!nrst)
      in_pd_out <= 1'b0;
    else
      in_pd_out <= in_pd;
  end

  always @(posedge clk) begin
    if (!nrst)
      crs_out <= 1'b0;
    else
      crs_out <= ctrl_two_reg[`PDDS_BIT_HD_CRS] && half_duplex && mac_tx_en;
  end

  always @(posedge clk) begin
    if (!nrst)
      fallback_to_fast <= 1'b0;
    else
      fallback_to_fast <= ctrl_two_reg[`PDDS_BIT_FALLBACK] && an_enable && adv_fast && gig_fail;
  end

  always @(posedge clk) begin
    if (!nrst)
      ctrl_two_out <= `PDDS_CTRL_TWO_RESET;
    else
      ctrl_two_out <= ctrl_two_reg;
  end
endmodule // pdds_top

// ==== dv/pdds_checker_sva.sv ====
`timescale 1ns/1ps
module pdds_checker(input wire clk, nrst, mgmt_wr, mgmt_rd, input wire [4:0] mgmt_addr,
  input wire [15:0] mgmt_wdata, mgmt_rdata, ctrl_two_out, input wire energy_pin, mac_tx_en, half_duplex,
  input wire an_enable, adv_fast, gig_fail, sleep_pulse_out, in_pd_out, crs_out, fallback_to_fast);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_crs_follows: assert property (crs_out == (ctrl_two_out[15] & $past(half_duplex & mac_tx_en)))
    else $error("crs mismatch");
  a_fallback_follows: assert property (fallback_to_fast == (ctrl_two_out[11] & $past(an_enable & adv_fast & gig_fail)))
    else $error("fallback mismatch");
  a_read_ctrl_two: assert property (mgmt_rd && !mgmt_wr && mgmt_addr == 5'h16 |=> mgmt_rdata == ctrl_two_out)
    else $error("ctrl two read mismatch");
  a_write_ctrl_two: assert property (mgmt_wr && mgmt_addr == 5'h16 |=> ##1 ctrl_two_out == $past(mgmt_wdata, 2))
    else $error("ctrl two write lost");
  a_read_unmapped: assert property (mgmt_rd && mgmt_addr != 5'h15 && mgmt_addr != 5'h16 |=> mgmt_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_status_upper_zero: assert property (mgmt_rd && mgmt_addr == 5'h15 |=> mgmt_rdata[15:4] == 12'h000)
    else $error("status upper bits set");
  a_rdata_holds: assert property (!mgmt_rd |=> $stable(mgmt_rdata)) else $error("read data moved");
  a_pulse_only_asleep: assert property (sleep_pulse_out |-> in_pd_out) else $error("pulse while awake");
  a_wake_on_energy: assert property (in_pd_out && energy_pin |-> ##[1:6] !in_pd_out)
    else $error("no wake on energy");
  c_crs: cover property (crs_out);
  c_fallback: cover property (fallback_to_fast);
  c_wake: cover property ($fell(in_pd_out));
  c_burst: cover property ($rose(sleep_pulse_out));
endmodule // pdds_checker
bind pdds_top pdds_checker chk_u (.*);

// ==== dv/pdds_mgmt_model.sv ====
`timescale 1ns/1ps
module pdds_mgmt_model(input wire clk, output logic mgmt_wr, mgmt_rd, output logic [4:0] mgmt_addr,
  output logic [15:0] mgmt_wdata, input wire [15:0] mgmt_rdata);
  initial {mgmt_wr, mgmt_rd, mgmt_addr, mgmt_wdata} = '0;
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge clk);
    {mgmt_wr, mgmt_rd, mgmt_addr, mgmt_wdata} <= {w, !w, a, d};
    @(posedge clk);
    // released lines show no stale value
    {mgmt_wr, mgmt_rd, mgmt_addr, mgmt_wdata} <= {2'b00, ~a, ~d};
    @(posedge clk);
    q = mgmt_rdata;
  endtask
endmodule // pdds_mgmt_model

// ==== dv/pdds_top_tb.sv ====
`timescale 1ns/1ps
module pdds_top_tb;
  logic clk = 0, nrst = 0, strap_pulse_pin = 1, strap_config_one = 1, strap_config_zero = 1, strap_pd_en_pin = 1;
  logic energy_pin = 1, mac_tx_en = 0, half_duplex = 0, an_enable = 0, adv_fast = 0, gig_fail = 0;
  logic mgmt_wr, mgmt_rd, sleep_pulse_out, in_pd_out, crs_out, fallback_to_fast;
  logic [4:0] mgmt_addr;
  logic [15:0] mgmt_wdata, mgmt_rdata, ctrl_two_out, q;
  int num_errors = 0, check_count = 0, cyc = 0, n;
  always #12.5 clk = ~clk;
  pdds_top #(.QUIET_CYCLES(50), .PULSE_CYCLES(20), .BURST_CYCLES(4)) dut_u (.*);
  pdds_mgmt_model mdl_u (.*);
  task chk(input string nm, input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask
  task rdchk(input logic [4:0] a, input logic [15:0] e);
    mdl_u.acc(0, a, 16'h0000, q);
    chk("rdata", q, e);
  endtask
  task wr(input logic [4:0] a, input logic [15:0] d);
    mdl_u.acc(1, a, d, q);
  endtask
  task t_regs;
    rdchk(5'h16, 16'h0b08);
    rdchk(5'h15, 16'h000c);
    wr(5'h16, 16'h8800);
    rdchk(5'h16, 16'h8800);
    wr(5'h15, 16'hffff);
    rdchk(5'h15, 16'h000d);
    rdchk(5'h05, 16'h0000);
    $display("test regs done");
  endtask
  task t_links;
    @(posedge clk);
    {half_duplex, mac_tx_en, an_enable, adv_fast, gig_fail} <= 5'h1f;
    repeat (3) @(posedge clk);
    #1 chk("crs", crs_out, 1);
    chk("fallback", fallback_to_fast, 1);
    @(posedge clk);
    {half_duplex, adv_fast} <= 2'b00;
    repeat (3) @(posedge clk);
    #1 chk("crs", crs_out, 0);
    chk("fallback", fallback_to_fast, 0);
    $display("test links done");
  endtask
  task t_sleep;
    wr(5'h15, 16'h000c);
    energy_pin <= 0;
    for (n = 0; n < 300 && sleep_pulse_out !== 1; n++) @(posedge clk);
    #1 chk("pulse", sleep_pulse_out, 1);
    chk("in_pd", in_pd_out, 1);
    rdchk(5'h15, 16'h000e);
    wr(5'h15, 16'h0008);
    for (n = 0; n < 60; n++) begin
      @(posedge clk);
      #1 chk("pulse", sleep_pulse_out, 0);
    end
    @(posedge clk);
    energy_pin <= 1;
    repeat (6) @(posedge clk);
    #1 chk("in_pd", in_pd_out, 0);
    rdchk(5'h15, 16'h0008);
    $display("test sleep done");
  endtask
  task test_done;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      test_done;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1;
    repeat (4) @(posedge clk);
    t_regs;
    t_links;
    t_sleep;
    test_done;
  end
endmodule // pdds_top_tb
